// File: logic/scr_responder.sv
// Command interpreter and reply formatter for the sensor side of the one-wire bus
`timescale 1ns/10ps

module scr_responder #(
  parameter logic [63:0]        VENDOR      = "ACMEX   ",      // Arbitrary value
  parameter logic [47:0]        MODEL       = "PT01  ",        // Arbitrary value
  parameter logic [23:0]        VERSION     = "101",           // Arbitrary value
  parameter logic [103:0]       SERIAL      = "PT0-000042   ", // Arbitrary value
  parameter logic [5:0]         SERIAL_LEN  = 6'h0a,           // Characters of SERIAL used
  parameter logic [7:0]         SENSOR_TYPE = 8'h2a            // Arbitrary value
) (
  input  wire logic             clk,         // 40 MHz clock
  input  wire logic             rstn,        // Synchronous reset, active low
  input  wire scr_pkg::scr_char_t rx,        // Received command character
  output scr_pkg::scr_char_t    tx,          // Reply character to send
  input  wire logic             tx_ready,    // Framer takes tx this cycle
  output logic                  meas_start,  // One-cycle request for a reading
  input  wire logic             meas_done,   // One-cycle pulse, reading ready
  input  wire scr_pkg::scr_meas_t meas_data, // Reading, valid with meas_done
  input  wire scr_pkg::scr_meta_t meta,      // Checksum and CRC characters
  output logic [7:0]            addr,        // Current bus address
  output logic                  busy         // Reply in progress
);
  import scr_pkg::*;

  scr_state_t               state_r;
  scr_kind_t                kind_r;
  logic [IDX_W-1:0]         idx_r;
  logic [7:0]               addr_r;
  logic [7:0]               cmd_r [CMD_MAX];
  logic [CNT_W-1:0]         cnt_r;
  logic                     pend_r;
  scr_mkind_t               mkind_r;
  scr_meas_t                data_r;
  logic                     data_ok_r;
  logic                     notify_r;
  scr_kind_t                notify_kind_r;
  scr_char_t                tx_r;
  logic                     meas_start_r;
  logic                     busy_r;

  logic                     dec_go;
  scr_kind_t                dec_kind;
  logic                     dec_meas;
  scr_mkind_t               dec_mkind;
  logic                     dec_addr_we;
  logic                     launch;
  scr_kind_t                launch_kind;
  logic [BODY_W-1:0]        body;
  logic [BODY_W-1:0]        tail;
  logic [IDX_W-1:0]         blen;
  logic [IDX_W-1:0]         tlen;
  logic [7:0]               cur;
  logic [7:0]               rx_ch;
  logic                     addr_hit;
  logic                     addr_exact;
  logic                     send_done;

  function automatic logic [7:0] pick(input logic [BODY_W-1:0] s, input logic [IDX_W-1:0] i);
    pick = s[BODY_W-8-8*int'(i) +: 8];
  endfunction

  function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    in_range = c >= lo && c <= hi;
  endfunction

  function automatic logic is_alnum(input logic [7:0] c);
    is_alnum = in_range(c, CH_ZERO, CH_NINE) || in_range(c, CH_A, CH_UP_Z) ||
               in_range(c, CH_LO_A, CH_LO_Z);
  endfunction

  // Wildcard is honoured only where the caller allows it
  function automatic logic addr_match(input logic [7:0] c, input logic [7:0] own, input logic wild);
    addr_match = (c == own) || (wild && c == CH_QM);
  endfunction

  function automatic logic [7:0] digit(input logic [3:0] n);
    digit = {DIGIT_HI, n};
  endfunction

  function automatic logic [7:0] sign(input logic neg);
    sign = neg ? CH_MINUS : CH_PLUS;
  endfunction

  // Data body behind the address; the point sits at a fixed digit count from the front end
  function automatic logic [(DATA_LEN-ADDR_LEN)*8-1:0] fmt_data(input scr_meas_t m);
    fmt_data = {sign(m.p_neg),
                digit(m.p_bcd[23:20]), digit(m.p_bcd[19:16]), digit(m.p_bcd[15:12]),
                CH_DOT,
                digit(m.p_bcd[11:8]), digit(m.p_bcd[7:4]), digit(m.p_bcd[3:0]),
                sign(m.t_neg),
                digit(m.t_bcd[15:12]), digit(m.t_bcd[11:8]),
                CH_DOT,
                digit(m.t_bcd[7:4]), digit(m.t_bcd[3:0]),
                CH_PLUS, digit(m.status)};
  endfunction

  assign rx_ch      = {1'b0, rx.ch};
  assign addr_hit   = addr_match(cmd_r[0], addr_r, 1'b1);
  assign addr_exact = addr_match(cmd_r[0], addr_r, 1'b0);

  // Decode a complete command on its terminating character
  always_comb begin
    dec_go      = 1'b0;
    dec_kind    = K_ADDR;
    dec_meas    = 1'b0;
    dec_mkind   = MK_M;
    dec_addr_we = 1'b0;
    if (state_r == ST_IDLE && rx.valid && rx_ch == CH_BANG && addr_hit) begin
      case (cnt_r)
        CNT_ONE: begin
          dec_go = 1'b1;
        end
        CNT_TWO: begin
          case (cmd_r[1])
            CH_I: begin
              dec_go   = 1'b1;
              dec_kind = K_ID;
            end
            CH_M: begin
              dec_go    = 1'b1;
              dec_kind  = K_ACKM;
              dec_meas  = 1'b1;
              dec_mkind = MK_M;
            end
            CH_C: begin
              dec_go    = 1'b1;
              dec_kind  = K_ACKC;
              dec_meas  = 1'b1;
              dec_mkind = MK_C;
            end
            default: dec_go = 1'b0;
          endcase
        end
        // Change-address needs the exact address; a wildcard there would rename every sensor
        CNT_THREE: begin
          if (cmd_r[1] == CH_A && addr_exact && is_alnum(cmd_r[2])) begin
            dec_go      = 1'b1;
            dec_addr_we = 1'b1;
          end else if (cmd_r[1] == CH_D && cmd_r[2] == CH_ZERO) begin
            dec_go   = 1'b1;
            dec_kind = data_ok_r ? K_DATA : K_ADDR;
          end else if (cmd_r[1] == CH_R && cmd_r[2] == CH_ZERO) begin
            dec_meas  = 1'b1;
            dec_mkind = MK_R;
          end
        end
        default: dec_go = 1'b0;
      endcase
    end
  end

  // A fresh command wins the idle slot; a pending notice goes out on the next one, unless that command starts a measurement, which drops it
  assign launch      = state_r == ST_IDLE && (dec_go || notify_r);
  assign launch_kind = dec_go ? dec_kind : notify_kind_r;

  // Command character buffer; characters beyond the buffer spoil the command
  // A stray terminator with nothing buffered only clears the count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= '0;
      for (int i = 0; i < CMD_MAX; i++) begin
        cmd_r[i] <= CH_END;
      end
    end else if (state_r == ST_SEND) begin
      cnt_r <= '0;
    end else if (rx.valid) begin
      if (rx_ch == CH_BANG) begin
        cnt_r <= '0;
      end else if (cnt_r != CNT_FULL) begin
        cmd_r[cnt_r[1:0]] <= rx_ch;
        cnt_r             <= cnt_r + CNT_ONE;
      end
    end
  end

  // New address is live from the decode edge, so the reply already carries it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_r <= ADDR_RST;
    end else if (dec_addr_we) begin
      addr_r <= cmd_r[2];
    end
  end

  // Measurement bookkeeping; a new measure command supersedes an unfinished one
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_r        <= 1'b0;
      mkind_r       <= MK_M;
      data_r        <= '0;
      data_ok_r     <= 1'b0;
      notify_r      <= 1'b0;
      notify_kind_r <= K_ADDR;
      meas_start_r  <= 1'b0;
    end else begin
      meas_start_r <= dec_meas;
      if (dec_meas) begin
        pend_r    <= 1'b1;
        mkind_r   <= dec_mkind;
        data_ok_r <= 1'b0;
        notify_r  <= 1'b0;
      end else if (meas_done && pend_r) begin
        pend_r    <= 1'b0;
        data_r    <= meas_data;
        data_ok_r <= 1'b1;
        // A concurrent reading stays silent until the logger asks for it
        notify_r  <= mkind_r != MK_C;
        notify_kind_r <= (mkind_r == MK_R) ? K_DATAR : K_ADDR;
      end else if (launch && !dec_go) begin
        notify_r <= 1'b0;
      end
    end
  end

  // Reply body, left aligned
  always_comb begin
    body = '0;
    blen = LEN_ADDR;
    body[BODY_W-1 -: 8] = addr_r;
    case (kind_r)
      K_ID: begin
        body[BODY_W-1 -: ID_FIXED_LEN*8] = {addr_r, CH_ONE, CH_THREE, VENDOR, MODEL, VERSION};
        body[BODY_W-1-ID_FIXED_LEN*8 -: SER_MAX*8] = SERIAL;
        blen = LEN_ID + SERIAL_LEN;
      end
      K_ACKM: begin
        body[BODY_W-1 -: ACKM_LEN*8] = {addr_r, ACK_WAIT_S, ACK_COUNT1};
        blen = LEN_ACKM;
      end
      K_ACKC: begin
        body[BODY_W-1 -: ACKC_LEN*8] = {addr_r, ACK_WAIT_S, ACK_COUNT2};
        blen = LEN_ACKC;
      end
      K_DATA, K_DATAR: begin
        body[BODY_W-1 -: DATA_LEN*8] = {addr_r, fmt_data(data_r)};
        blen = LEN_DATA;
      end
      default: blen = LEN_ADDR;
    endcase
  end

  // Reply tail; only the continuous read carries metadata
  // Metadata is read live, so the checksum block must hold it for the whole reply
  always_comb begin
    tail = '0;
    if (kind_r == K_DATAR) begin
      tail[BODY_W-1 -: TAIL_META*8] = {CH_CR, SENSOR_TYPE, meta.sum, meta.crc, CH_CR, CH_LF};
      tlen = LEN_TMET;
    end else begin
      tail[BODY_W-1 -: TAIL_STD*8] = {CH_CR, CH_LF};
      tlen = LEN_TSTD;
    end
  end

  always_comb begin
    if (idx_r < blen) begin
      cur = pick(body, idx_r);
    end else if (idx_r < blen + tlen) begin
      cur = pick(tail, idx_r - blen);
    end else begin
      cur = CH_END;
    end
  end

  // Reply sequencer: one character offered at a time, held until taken
  // The next character loads on the take edge, so a framer that never stalls sees no gaps
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      kind_r  <= K_ADDR;
      idx_r   <= '0;
      tx_r    <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (launch) begin
            state_r <= ST_SEND;
            kind_r  <= launch_kind;
            idx_r   <= '0;
          end
        end
        ST_SEND: begin
          if (!tx_r.valid || tx_ready) begin
            if (cur == CH_END) begin
              tx_r.valid <= 1'b0;
              state_r    <= ST_IDLE;
            end else begin
              tx_r.valid <= 1'b1;
              tx_r.ch    <= cur[6:0];
              idx_r      <= idx_r + 1'b1;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Last character taken and nothing left to offer
  assign send_done = state_r == ST_SEND && (!tx_r.valid || tx_ready) && cur == CH_END;

  // Own flop so the port follows the sequencer without hanging off its decode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_r <= 1'b0;
    end else if (launch) begin
      busy_r <= 1'b1;
    end else if (send_done) begin
      busy_r <= 1'b0;
    end
  end

  assign tx         = tx_r;
  assign meas_start = meas_start_r;
  assign addr       = addr_r;
  assign busy       = busy_r;

endmodule

// File: include/scr_pkg.sv
// Constants, character codes and carrier types for the sensor command responder
package scr_pkg;

  // Character codes
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_QM    = 8'h3f;
  localparam logic [7:0] CH_BANG  = 8'h21;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ONE   = 8'h31;
  localparam logic [7:0] CH_THREE = 8'h33;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_C     = 8'h43;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_I     = 8'h49;
  localparam logic [7:0] CH_M     = 8'h4d;
  localparam logic [7:0] CH_R     = 8'h52;
  localparam logic [7:0] CH_END   = 8'h00;
  localparam logic [7:0] CH_LO_A  = 8'h61;
  localparam logic [7:0] CH_LO_Z  = 8'h7a;
  localparam logic [7:0] CH_UP_Z  = 8'h5a;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [3:0] DIGIT_HI = 4'h3;

  // Address as shipped
  localparam logic [7:0] ADDR_RST = CH_ZERO;

  // Measurement acknowledgement fields: wait time in seconds and value counts
  localparam logic [23:0] ACK_WAIT_S   = {CH_ZERO, CH_ZERO, CH_ONE};
  localparam logic [7:0]  ACK_COUNT1   = CH_THREE;
  localparam logic [15:0] ACK_COUNT2   = {CH_ZERO, CH_THREE};

  // Reply geometry in characters, with the BODY_W, IDX_W and CNT_W widths in bits
  localparam int unsigned BODY_MAX     = 33;
  localparam int unsigned BODY_W       = BODY_MAX * 8;
  localparam int unsigned IDX_W        = 6;
  localparam int unsigned SER_MAX      = 13;
  localparam int unsigned ID_FIXED_LEN = 20;
  localparam int unsigned ACKM_LEN     = 5;
  localparam int unsigned ACKC_LEN     = 6;
  localparam int unsigned DATA_LEN     = 17;
  localparam int unsigned ADDR_LEN     = 1;
  localparam int unsigned TAIL_STD     = 2;
  localparam int unsigned TAIL_META    = 6;
  localparam int unsigned CMD_MAX      = 4;
  localparam int unsigned CNT_W        = 3;

  localparam logic [IDX_W-1:0] LEN_ID   = IDX_W'(ID_FIXED_LEN);
  localparam logic [IDX_W-1:0] LEN_ACKM = IDX_W'(ACKM_LEN);
  localparam logic [IDX_W-1:0] LEN_ACKC = IDX_W'(ACKC_LEN);
  localparam logic [IDX_W-1:0] LEN_DATA = IDX_W'(DATA_LEN);
  localparam logic [IDX_W-1:0] LEN_ADDR = IDX_W'(ADDR_LEN);
  localparam logic [IDX_W-1:0] LEN_TSTD = IDX_W'(TAIL_STD);
  localparam logic [IDX_W-1:0] LEN_TMET = IDX_W'(TAIL_META);

  localparam logic [CNT_W-1:0] CNT_ONE   = 3'h1;
  localparam logic [CNT_W-1:0] CNT_TWO   = 3'h2;
  localparam logic [CNT_W-1:0] CNT_THREE = 3'h3;
  localparam logic [CNT_W-1:0] CNT_FULL  = 3'h4;

  typedef enum logic [2:0] {
    K_ADDR  = 3'h0,
    K_ID    = 3'h1,
    K_ACKM  = 3'h3,
    K_ACKC  = 3'h2,
    K_DATA  = 3'h6,
    K_DATAR = 3'h7
  } scr_kind_t;

  typedef enum logic [1:0] {
    MK_M = 2'h0,
    MK_C = 2'h1,
    MK_R = 2'h3
  } scr_mkind_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } scr_state_t;

  // One character from or to the line framer
  typedef struct packed {
    logic       valid;
    logic [6:0] ch;
  } scr_char_t;

  // Reading from the transducer front end, in BCD
  typedef struct packed {
    logic        p_neg;
    logic [23:0] p_bcd;
    logic        t_neg;
    logic [15:0] t_bcd;
    logic [3:0]  status;
  } scr_meas_t;

  // Metadata characters made by the checksum block
  typedef struct packed {
    logic [7:0] sum;
    logic [7:0] crc;
  } scr_meta_t;

endpackage

// File: testbench/scr_responder_props.sv
// Port-level assertions for the sensor command responder
`timescale 1ns/10ps
module scr_responder_props (
  input wire logic               clk,        // Clock
  input wire logic               rstn,       // Reset, active low
  input wire scr_pkg::scr_char_t tx,         // Reply character
  input wire logic               tx_ready,   // Framer take
  input wire logic               meas_start, // Reading request
  input wire logic [7:0]         addr,       // Bus address
  input wire logic               busy        // Reply in progress
);
  import scr_pkg::*;
  logic       fresh_r;
  logic [6:0] first_r;
  logic [6:0] last_r;
  logic [6:0] prev_r;
  wire        take = tx.valid & tx_ready;

  // First taken character of each reply
  always_ff @(posedge clk) begin
    if (!rstn || !busy) fresh_r <= 1'b1;
    else if (take) fresh_r <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (take && fresh_r) first_r <= tx.ch;
  end
  // Last two taken characters, for the terminator
  always_ff @(posedge clk) begin
    if (take) begin
      last_r <= tx.ch;
      prev_r <= last_r;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_lead;
    ##1 tx.valid;
  endsequence

  a_reset_idle: assert property (disable iff (1'b0) !rstn |=> !tx.valid && !busy && !meas_start && addr == ADDR_RST)
    else $error("outputs not idle after reset");
  a_tx_hold: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.ch))
    else $error("reply character dropped or changed before take");
  a_busy_lead: assert property ($rose(busy) |-> s_lead)
    else $error("reply did not start one cycle after busy");
  a_first_addr: assert property ($fell(busy) |-> first_r == addr[6:0])
    else $error("reply did not begin with the address");
  a_tail_crlf: assert property ($fell(busy) |-> prev_r == CH_CR[6:0] && last_r == CH_LF[6:0])
    else $error("reply not closed by CR LF");
  a_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("reading request longer than one cycle");
  a_addr_alnum: assert property (addr inside {[8'h30:8'h39], [8'h41:8'h5a], [8'h61:8'h7a]})
    else $error("address not alphanumeric");
  a_quiet_idle: assert property (!busy |-> !tx.valid)
    else $error("line driven outside a reply");
endmodule

bind scr_responder scr_responder_props u_props (.clk(clk), .rstn(rstn), .tx(tx), .tx_ready(tx_ready),
                                                .meas_start(meas_start), .addr(addr), .busy(busy));

// File: testbench/scr_logger_model.sv
// Logger-side model: takes reply characters, stalling when told
`timescale 1ns/10ps
module scr_logger_model (
  input  wire logic               clk,     // Clock
  input  wire logic               rstn,    // Reset, active low
  input  wire scr_pkg::scr_char_t tx,      // Reply character
  input  wire logic               stall,   // Hold off takes
  output logic                    tx_ready // Take strobe
);
  import scr_pkg::*;
  // Unbounded, so the long identification reply always fits
  logic [7:0] got[$];
  always @(posedge clk) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
    end else begin
      if (tx.valid && tx_ready) got.push_back({1'b0, tx.ch});
      tx_ready <= !stall;
    end
  end
endmodule

// File: testbench/test_sdi12_sensor_command_responder.sv
// Self-checking bench for the sensor command responder
`timescale 1ns/10ps
module test_sdi12_sensor_command_responder;
  import scr_pkg::*;
  localparam string CRLF = "\015\012";
  logic       clk       = 1'b0;
  logic       rstn      = 1'b0;
  scr_char_t  rx        = '0;
  scr_char_t  tx;
  logic       tx_ready;
  logic       meas_start;
  logic       meas_done = 1'b0;
  scr_meas_t  meas_data = '0;
  scr_meta_t  meta      = '0;
  logic [7:0] addr;
  logic       busy;
  logic       stall     = 1'b0;
  logic       slow      = 1'b0;
  int         fails     = 0;
  int         checked   = 0;
  int         seed      = 35181;
  string      a         = "0";
  string      rd;
  string      bad       = "/:@[\140{";
  string      good      = "5zA9";

  always #12.5 clk = ~clk;

  scr_responder DUT (.clk(clk), .rstn(rstn), .rx(rx), .tx(tx), .tx_ready(tx_ready), .meas_start(meas_start),
                     .meas_done(meas_done), .meas_data(meas_data), .meta(meta), .addr(addr), .busy(busy));
  scr_logger_model LOG (.clk(clk), .rstn(rstn), .tx(tx), .stall(stall), .tx_ready(tx_ready));

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 32'h7fffffff;
  endfunction
  function automatic logic [3:0] dig();
    return 4'(rnd() % 10);
  endfunction
  function automatic string sg(logic n);
    return n ? "-" : "+";
  endfunction

  always @(posedge clk) stall <= slow && (rnd() % 3 == 0);

  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic timeout();
    fails++;
    $display("MISMATCH at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  task automatic send(string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      rx <= {1'b1, s[i][6:0]};
    end
    @(posedge clk);
    rx <= '0;
  endtask

  // Empty string means silence is expected
  task automatic expect_reply(string e);
    int n;
    n = 0;
    if (e.len() == 0) repeat (30) @(posedge clk);
    while (LOG.got.size() < e.len() || busy !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 3000) timeout();
    end
    check(8'(LOG.got.size()), 8'(e.len()));
    foreach (LOG.got[i]) if (i < e.len()) check(LOG.got[i], e[i]);
    LOG.got.delete();
  endtask

  // Front end: answers a request late, so acknowledgements finish first
  task automatic measure();
    scr_meas_t m;
    int        n;
    n = 0;
    while (meas_start !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 50) timeout();
    end
    check(8'(n), 8'h01);
    repeat (100 + rnd() % 50) @(posedge clk);
    m = {1'(rnd()), dig(), dig(), dig(), dig(), dig(), dig(), 1'(rnd()), dig(), dig(), dig(), dig(), dig()};
    rd = $sformatf("%s%03h.%03h%s%02h.%02h+%0h", sg(m.p_neg), m.p_bcd[23:12], m.p_bcd[11:0], sg(m.t_neg),
                   m.t_bcd[15:8], m.t_bcd[7:0], m.status);
    meas_data <= m;
    meta      <= {8'h21 + 8'(rnd() % 90), 8'h30 + 8'(rnd() % 64)};
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(addr, ADDR_RST);
    send("0D0!");
    expect_reply({"0", CRLF});
    send("?!");
    expect_reply({"0", CRLF});
    slow = 1'b1;
    send("?I!");
    expect_reply({"013ACMEX   PT01  101PT0-000042", CRLF});
    for (int i = 0; i < bad.len(); i++) begin
      send({"0A", bad.substr(i, i), "!"});
      expect_reply("");
      check(addr, ADDR_RST);
    end
    send("?A5!");
    expect_reply("");
    for (int i = 0; i < good.len(); i++) begin
      send({a, "A", good.substr(i, i), "!"});
      a = good.substr(i, i);
      expect_reply({a, CRLF});
      check(addr, a[0]);
    end
    send("0!");
    expect_reply("");
    send({a, "!"});
    expect_reply({a, CRLF});
    send({a, "M!"});
    fork
      measure();
      expect_reply({a, "0013", CRLF});
    join
    expect_reply({a, CRLF});
    send("?D0!");
    expect_reply({a, rd, CRLF});
    send({a, "C!"});
    fork
      measure();
      expect_reply({a, "00103", CRLF});
    join
    expect_reply("");
    send({a, "D0!"});
    expect_reply({a, rd, CRLF});
    send({a, "R0!"});
    fork
      measure();
      expect_reply("");
    join
    expect_reply($sformatf("%s%s\015*%c%c%s", a, rd, meta.sum, meta.crc, CRLF));
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(addr, ADDR_RST);
    send("?!");
    expect_reply({"0", CRLF});
    report_and_stop();
  end
endmodule
